/* File: test_two_way_instruction_cache.sv */
`timescale 1ns/100ps
module test_two_way_instruction_cache;
	import twic_pkg::*;
	typedef struct packed {logic [31:0] addr; logic hit; logic slow;} twic_row_t;
	logic        ref_clk, resetn, fetchReq, fetchReady, fetchValid, busReq, busAck, busBeatValid, slow;
	logic [31:0] fetchAddr, fetchData, busAddr, busBeatData, baseRegister, indexRegister, lockAddr;
	logic        invReq, baseFieldZero, supervisor, loadAllowed, invDone, invPrivErr, invStorageErr;
	logic        lockReq, lockSet, lockDone, lockHit;
	int          failCount, nCompared;
	twic_row_t   rows[10] = '{
		'{32'h0000_1008, 1'b0, 1'b1}, '{32'h0000_1000, 1'b1, 1'b0}, '{32'h0000_100c, 1'b1, 1'b0},
		'{32'h0000_2008, 1'b0, 1'b0}, '{32'h0000_1004, 1'b1, 1'b0}, '{32'h0000_3004, 1'b0, 1'b1},
		'{32'h0000_1000, 1'b1, 1'b0}, '{32'h0000_2000, 1'b0, 1'b0}, '{32'h0000_0ff4, 1'b0, 1'b0},
		'{32'h0000_0ff0, 1'b1, 1'b0}};

	twic_cache DUT (.ref_clk(ref_clk), .resetn(resetn), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
		.fetchReady(fetchReady), .fetchValid(fetchValid), .fetchData(fetchData), .busReq(busReq),
		.busAddr(busAddr), .busAck(busAck), .busBeatValid(busBeatValid), .busBeatData(busBeatData),
		.invReq(invReq), .baseFieldZero(baseFieldZero), .baseRegister(baseRegister),
		.indexRegister(indexRegister), .supervisor(supervisor), .loadAllowed(loadAllowed),
		.invDone(invDone), .invPrivErr(invPrivErr), .invStorageErr(invStorageErr), .lockReq(lockReq),
		.lockSet(lockSet), .lockAddr(lockAddr), .lockDone(lockDone), .lockHit(lockHit));
	twic_bus_model model (.ref_clk(ref_clk), .busReq(busReq), .busAddr(busAddr), .slow(slow),
		.busAck(busAck), .busBeatValid(busBeatValid), .busBeatData(busBeatData));

	always #4 ref_clk = ~ref_clk;

	function automatic logic [31:0] memWord(input logic [31:0] a);
		return {a[31:2], 2'h0} ^ 32'h5a3c_0f96;
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			failCount++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stopTest;
		$display("compared %0d mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic cycle(inout int n);
		@(posedge ref_clk);
		#1;
		if (++n > 60) begin
			failCount++;
			stopTest();
		end
	endtask
	task automatic waitReady;
		int n = 0;
		while (fetchReady !== 1'b1) cycle(n);
		@(posedge ref_clk);
		#1;
	endtask
	// fetchReq stays up after a hit so hits can run back to back
	task automatic fetch(input logic [31:0] a, input logic hit);
		int n = 0;
		fetchReq = 1'b1;
		fetchAddr = a;
		waitReady();
		if (fetchValid !== 1'b1) fetchReq = 1'b0;
		while (fetchValid !== 1'b1) cycle(n);
		check("fetch data", fetchData, memWord(a));
		check("hit", 32'(n == 0), 32'(hit));
		if (!hit) check("burst address", busAddr, {a[31:2], 2'h0});
	endtask
	task automatic lock(input logic [31:0] a, input logic set, input logic [1:0] exp);
		fetchReq = 1'b0;
		@(posedge ref_clk);
		#1 lockReq = 1'b1;
		lockSet = set;
		lockAddr = a;
		waitReady();
		lockReq = 1'b0;
		check("lock result", {30'h0, lockDone, lockHit}, {30'h0, exp});
	endtask
	task automatic inv(input logic [31:0] b, input logic fz, input logic [31:0] x, input logic sup,
		input logic ld, input logic [2:0] exp);
		fetchReq = 1'b0;
		@(posedge ref_clk);
		#1 invReq = 1'b1;
		{baseRegister, baseFieldZero, indexRegister, supervisor, loadAllowed} = {b, fz, x, sup, ld};
		waitReady();
		invReq = 1'b0;
		check("invalidate result", {29'h0, invDone, invPrivErr, invStorageErr}, {29'h0, exp});
	endtask

	initial begin
		{ref_clk, resetn, fetchReq, fetchAddr, invReq, baseFieldZero, baseRegister} = '0;
		{indexRegister, supervisor, loadAllowed, lockReq, lockSet, lockAddr, slow} = '0;
		failCount = 0;
		nCompared = 0;
		repeat (8) @(posedge ref_clk);
		#1 resetn = 1'b1;
		// idle takes requests on the first edge already, before fetchReady rises
		@(posedge ref_clk);
		#1;
		foreach (rows[i]) begin
			slow = rows[i].slow;
			fetch(rows[i].addr, rows[i].hit);
		end
		lock(32'h0000_1000, 1'b1, 2'b11);
		lock(32'h0000_5000, 1'b1, 2'b10);
		fetch(32'h0000_3000, 1'b0);
		fetch(32'h0000_1008, 1'b1);
		inv(32'h0, 1'b0, 32'h0000_3000, 1'b0, 1'b1, 3'b010);
		inv(32'h0, 1'b0, 32'h0000_3000, 1'b1, 1'b0, 3'b001);
		fetch(32'h0000_3004, 1'b1);
		inv(32'hdead_beef, 1'b1, 32'h0000_3000, 1'b1, 1'b1, 3'b100);
		fetch(32'h0000_3000, 1'b0);
		inv(32'h0000_1000, 1'b0, 32'h0000_0004, 1'b1, 1'b1, 3'b100);
		fetch(32'h0000_1000, 1'b0);
		// both ways locked: the miss is forwarded but not kept
		lock(32'h0000_1000, 1'b1, 2'b11);
		fetch(32'h0000_2000, 1'b0);
		fetch(32'h0000_2000, 1'b0);
		lock(32'h0000_1000, 1'b0, 2'b11);
		fetch(32'h0000_2000, 1'b0);
		fetch(32'h0000_2004, 1'b1);
		fetchReq = 1'b0;
		resetn = 1'b0;
		repeat (8) @(posedge ref_clk);
		#1;
		check("outputs in reset", {29'h0, fetchReady, busReq, fetchValid}, 32'h0);
		resetn = 1'b1;
		@(posedge ref_clk);
		#1;
		fetch(32'h0000_3000, 1'b0);
		stopTest();
	end
endmodule // test_two_way_instruction_cache

/* File: twic_bus_model.sv */
`timescale 1ns/100ps
// instruction bus memory: acks a burst read, then four beats
module twic_bus_model (
	// clock
	input  wire logic        ref_clk,
	// burst read
	input  wire logic        busReq,
	input  wire logic [31:0] busAddr,
	input  wire logic        slow,
	output logic             busAck,
	output logic             busBeatValid,
	output logic      [31:0] busBeatData
);
	logic [31:0] base;
	logic [1:0]  word;
	logic        slowNow;   // latched per burst: the bench may change slow mid-fill
	initial begin
		busAck = 1'b0;
		busBeatValid = 1'b0;
		busBeatData = 32'h0;
		forever begin
			@(posedge ref_clk);
			if (busReq === 1'b1) begin
				base = busAddr;
				slowNow = slow;
				if (slowNow) repeat (3) @(posedge ref_clk);
				#1 busAck = 1'b1;
				@(posedge ref_clk);
				#1 busAck = 1'b0;
				for (int k = 0; k < 4; k++) begin
					word = base[3:2] + 2'(k);
					busBeatValid = 1'b1;
					busBeatData = {base[31:4], word, 2'h0} ^ 32'h5a3c_0f96;
					@(posedge ref_clk);
					#1;
					// released data lines must not look like a held beat
					if (slowNow || k == 3) begin
						busBeatValid = 1'b0;
						busBeatData = ~busBeatData;
					end
					if (slowNow && k < 3) begin
						repeat (2) @(posedge ref_clk);
						#1;
					end
				end
			end
		end
	end
endmodule // twic_bus_model

/* File: twic_cache.sv */
`timescale 1ns/100ps
module twic_cache (
	// clock and reset
	input  wire logic                            ref_clk,
	input  wire logic                            resetn,
	// instruction fetch
	input  wire logic                            fetchReq,
	input  wire logic [twic_pkg::ADDR_BITS-1:0]  fetchAddr,
	output logic                                 fetchReady,
	output logic                                 fetchValid,
	output logic      [twic_pkg::WORD_BITS-1:0]  fetchData,
	// instruction bus burst read
	output logic                                 busReq,
	output logic      [twic_pkg::ADDR_BITS-1:0]  busAddr,
	input  wire logic                            busAck,
	input  wire logic                            busBeatValid,
	input  wire logic [twic_pkg::WORD_BITS-1:0]  busBeatData,
	// block invalidate
	input  wire logic                            invReq,
	input  wire logic                            baseFieldZero,
	input  wire logic [twic_pkg::ADDR_BITS-1:0]  baseRegister,
	input  wire logic [twic_pkg::ADDR_BITS-1:0]  indexRegister,
	input  wire logic                            supervisor,
	input  wire logic                            loadAllowed,
	output logic                                 invDone,
	output logic                                 invPrivErr,
	output logic                                 invStorageErr,
	// line lock
	input  wire logic                            lockReq,
	input  wire logic                            lockSet,
	input  wire logic [twic_pkg::ADDR_BITS-1:0]  lockAddr,
	output logic                                 lockDone,
	output logic                                 lockHit
);
	import twic_pkg::*;

	localparam int LINES = NUM_WAYS * NUM_SETS;

	twic_state_t          state_reg;
	logic [WORD_BITS-1:0] dataArr [LINES*LINE_WORDS];
	logic [TAG_W-1:0]     tagArr  [LINES];
	logic [NUM_SETS-1:0]  valid_reg [NUM_WAYS];
	logic [NUM_SETS-1:0]  lock_reg  [NUM_WAYS];
	logic [NUM_SETS-1:0]  lru_reg;                        // 1: way 1 is next victim

	logic                 ready_reg, fetchValid_reg, busReq_reg;
	logic [WORD_BITS-1:0] fetchData_reg;
	logic [ADDR_BITS-1:0] busAddr_reg, fillAddr_reg;
	logic                 invDone_reg, invPrivErr_reg, invStorageErr_reg, lockDone_reg, lockHit_reg;
	logic [OFS_W-1:0]     beatCnt_reg;
	logic                 fillWay_reg, fillOk_reg;

	logic [ADDR_BITS-1:0] effectiveAddress, lkAddr;
	logic [IDX_W-1:0]     lkIdx, fillIdx;
	logic [TAG_W-1:0]     lkTag;
	logic [OFS_W-1:0]     lkOfs, fillOfs;
	logic [NUM_WAYS-1:0]  wayHit;
	logic                 anyHit, hitWay, victimWay, victimOk;
	logic                 idle, takeFetch, takeHit, takeMiss, takeInv, takeLock, invAllowed, beat, lastBeat;
	logic [WORD_BITS-1:0] hitData;

	assign effectiveAddress = (baseFieldZero ? '0 : baseRegister) + indexRegister;
	// one shared lookup port; invalidate beats lock beats fetch
	assign lkAddr    = invReq ? effectiveAddress : (lockReq ? lockAddr : fetchAddr);
	assign lkIdx     = lkAddr[IDX_LSB +: IDX_W];
	assign lkTag     = lkAddr[TAG_LSB +: TAG_W];
	assign lkOfs     = lkAddr[OFS_LSB +: OFS_W];
	assign fillIdx   = fillAddr_reg[IDX_LSB +: IDX_W];
	assign fillOfs   = fillAddr_reg[OFS_LSB +: OFS_W];

	genvar w;
	generate
		for (w = 0; w < NUM_WAYS; w++) begin : g_way
			assign wayHit[w] = valid_reg[w][lkIdx] && (tagArr[{1'(w), lkIdx}] == lkTag);
		end
	endgenerate

	assign anyHit     = |wayHit;
	assign hitWay     = wayHit[1];
	assign hitData    = dataArr[{hitWay, lkIdx, lkOfs}];
	assign idle       = (state_reg == ST_IDLE);
	assign takeInv    = idle && invReq;
	assign takeLock   = idle && !invReq && lockReq;
	assign takeFetch  = idle && !invReq && !lockReq && fetchReq;
	assign takeHit    = takeFetch && anyHit;
	assign takeMiss   = takeFetch && !anyHit;
	assign invAllowed = supervisor && loadAllowed;
	assign beat       = (state_reg == ST_FILL) && busBeatValid;
	assign lastBeat   = beat && (beatCnt_reg == BEAT_LAST);

	// victim choice; with both ways locked the miss is served uncached
	always_comb begin
		victimOk  = 1'b1;
		victimWay = 1'b0;
		if (!valid_reg[0][lkIdx] && !lock_reg[0][lkIdx])
			victimWay = 1'b0;
		else if (!valid_reg[1][lkIdx] && !lock_reg[1][lkIdx])
			victimWay = 1'b1;
		else if (!lock_reg[0][lkIdx] && !lock_reg[1][lkIdx])
			victimWay = lru_reg[lkIdx];
		else if (!lock_reg[0][lkIdx])
			victimWay = 1'b0;
		else if (!lock_reg[1][lkIdx])
			victimWay = 1'b1;
		else
			victimOk  = 1'b0;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			ready_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (takeMiss)
						state_reg <= ST_FILL;
				end
				ST_FILL: begin
					if (lastBeat)
						state_reg <= ST_IDLE;
				end
			endcase
			ready_reg <= idle ? !takeMiss : lastBeat;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			busReq_reg   <= 1'b0;
			busAddr_reg  <= '0;
			fillAddr_reg <= '0;
			fillWay_reg  <= 1'b0;
			fillOk_reg   <= 1'b0;
			beatCnt_reg  <= BEAT_FIRST;
		end else begin
			if (takeMiss) begin
				busReq_reg   <= 1'b1;
				busAddr_reg  <= {lkAddr[ADDR_BITS-1:OFS_LSB], WORD_ALIGN};
				fillAddr_reg <= {lkAddr[ADDR_BITS-1:OFS_LSB], WORD_ALIGN};
				fillWay_reg  <= victimWay;
				fillOk_reg   <= victimOk;
				beatCnt_reg  <= BEAT_FIRST;
			end else begin
				if (busAck)
					busReq_reg <= 1'b0;
				if (beat)
					beatCnt_reg <= beatCnt_reg + 2'h1;
			end
		end
	end

	// array contents carry no reset; the valid bits guard them
	always_ff @(posedge ref_clk) begin
		if (beat && fillOk_reg) begin
			// critical word first, wrapping inside the line
			dataArr[{fillWay_reg, fillIdx, fillOfs + beatCnt_reg}] <= busBeatData;
			if (beatCnt_reg == BEAT_FIRST)
				tagArr[{fillWay_reg, fillIdx}] <= fillAddr_reg[TAG_LSB +: TAG_W];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_WAYS; i++) begin
				valid_reg[i] <= '0;
				lock_reg[i]  <= '0;
			end
			lru_reg <= '0;
		end else begin
			// a line being refilled must not hit on half-written data
			if (takeMiss && victimOk)
				valid_reg[victimWay][lkIdx] <= 1'b0;
			if (lastBeat && fillOk_reg) begin
				valid_reg[fillWay_reg][fillIdx] <= 1'b1;
				lru_reg[fillIdx] <= !fillWay_reg;
			end
			if (takeHit)
				lru_reg[lkIdx] <= !hitWay;
			if (takeInv && invAllowed) begin
				for (int i = 0; i < NUM_WAYS; i++) begin
					if (wayHit[i])
						valid_reg[i][lkIdx] <= 1'b0;
				end
			end
			if (takeLock && anyHit)
				lock_reg[hitWay][lkIdx] <= lockSet;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fetchValid_reg <= 1'b0;
			fetchData_reg  <= '0;
		end else begin
			fetchValid_reg <= takeHit || (beat && beatCnt_reg == BEAT_FIRST);
			if (takeHit)
				fetchData_reg <= hitData;
			else if (beat && beatCnt_reg == BEAT_FIRST)
				fetchData_reg <= busBeatData;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			invDone_reg       <= 1'b0;
			invPrivErr_reg    <= 1'b0;
			invStorageErr_reg <= 1'b0;
			lockDone_reg      <= 1'b0;
			lockHit_reg       <= 1'b0;
		end else begin
			invDone_reg       <= takeInv && invAllowed;
			invPrivErr_reg    <= takeInv && !supervisor;
			invStorageErr_reg <= takeInv && supervisor && !loadAllowed;
			lockDone_reg      <= takeLock;
			lockHit_reg       <= takeLock && anyHit;
		end
	end

	assign fetchReady    = ready_reg;
	assign fetchValid    = fetchValid_reg;
	assign fetchData     = fetchData_reg;
	assign busReq        = busReq_reg;
	assign busAddr       = busAddr_reg;
	assign invDone       = invDone_reg;
	assign invPrivErr    = invPrivErr_reg;
	assign invStorageErr = invStorageErr_reg;
	assign lockDone      = lockDone_reg;
	assign lockHit       = lockHit_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_hit_returns_word: assert property (takeHit |=> fetchValid && fetchData == $past(hitData))
		else $error("hit did not return the selected word");
	a_miss_starts_burst: assert property (takeMiss |=> busReq && !fetchReady &&
		busAddr == {$past(lkAddr[ADDR_BITS-1:OFS_LSB]), WORD_ALIGN})
		else $error("miss did not start a burst at the missed address");
	a_first_beat_fwd: assert property (beat && beatCnt_reg == BEAT_FIRST |=>
		fetchValid && fetchData == $past(busBeatData))
		else $error("first beat not forwarded at once");
	a_four_beat_end: assert property (lastBeat |=> idle && fetchReady && !fetchValid)
		else $error("fill did not end after the fourth beat");
	a_lock_not_victim: assert property (takeMiss && victimOk |-> !lock_reg[victimWay][lkIdx])
		else $error("locked line chosen for replacement");
	a_invalid_first: assert property (takeMiss && !valid_reg[0][lkIdx] && !lock_reg[0][lkIdx]
		|-> victimWay == 1'b0)
		else $error("invalid line not preferred");
	a_inval_clears: assert property (takeInv && invAllowed && wayHit[0] |=>
		!valid_reg[0][$past(lkIdx)] && invDone)
		else $error("invalidate left the line valid");
	a_priv_check: assert property (takeInv && !supervisor |=> invPrivErr && !invDone)
		else $error("user-level invalidate not refused");
	a_lru_update: assert property (takeHit |=> lru_reg[$past(lkIdx)] == !$past(hitWay))
		else $error("recency bit not moved to the other way");
	a_fill_valid: assert property (lastBeat && fillOk_reg |=>
		valid_reg[$past(fillWay_reg)][$past(fillIdx)])
		else $error("filled line not marked valid");

	c_hit: cover property (takeHit);
	c_fill_done: cover property (lastBeat && fillOk_reg);
	c_invalidate: cover property (takeInv && invAllowed && anyHit);
	c_lock: cover property (takeLock && anyHit && lockSet);
	c_uncached: cover property (takeMiss && !victimOk);
endmodule // twic_cache

/* File: twic_pkg.sv */
package twic_pkg;
	// geometry: 4 KB = 2 ways x 128 sets x 4 words x 4 bytes
	localparam int CACHE_BYTES = 4096;
	localparam int NUM_WAYS    = 2;
	localparam int NUM_SETS    = 128;
	localparam int LINE_WORDS  = 4;
	localparam int WORD_BITS   = 32;
	localparam int ADDR_BITS   = 32;
	// address fields, lsb-0 numbering (msb-0 bits 0..20 tag, 21..27 set, 28..29 word)
	localparam int TAG_LSB     = 11;
	localparam int TAG_W       = 21;
	localparam int IDX_LSB     = 4;
	localparam int IDX_W       = 7;
	localparam int OFS_LSB     = 2;
	localparam int OFS_W       = 2;
	localparam logic [OFS_W-1:0] BEAT_FIRST = 2'h0;
	localparam logic [OFS_W-1:0] BEAT_LAST  = 2'h3;
	localparam logic [1:0]       WORD_ALIGN = 2'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FILL = 2'b10
	} twic_state_t;
endpackage
